// ==== verification/aci_bus_master.sv ====
// aci_bus_master: two-wire bus master stand-in with bit-level tasks
// assumes a pull-up on the data wire; clock stands high between frames
`timescale 1ns/1ps
module aci_bus_master (
   input wire logic lclk_i,
   output logic scl_o,
   output logic low_o,
   input wire logic sda_i
);
   // ****************
   // bus phases, a quarter bit is ten link clocks
   // ****************
   initial begin
      scl_o = 1'b1;
      low_o = 1'b0;
   end
   task automatic rep(input int n);
      repeat (n * 10) @(posedge lclk_i);
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      low_o = 1'b0;
      rep(1);
      scl_o = 1'b1;
      rep(1);
      low_o = 1'b1;
      rep(1);
      scl_o = 1'b0;
   endtask
   // stop: data rises while clock high, then bus free
   task automatic stop();
      low_o = 1'b1;
      rep(1);
      scl_o = 1'b1;
      rep(1);
      low_o = 1'b0;
      rep(2);
   endtask
   // one clock pulse, data set in low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
      rep(1);
      low_o = !b;
      rep(1);
      scl_o = 1'b1;
      rep(1);
      r = sda_i;
      rep(1);
      scl_o = 1'b0;
   endtask
   // eight bits then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
      bit_x(ack_in, ack_out);
   endtask
endmodule // aci_bus_master

// ==== verification/aci_monitor.sv ====
// aci_monitor: timing checks on the ports of the converter command interface
// assumes it is bound into aci_top and sees only that module's ports
`timescale 1ns/1ps
module aci_monitor (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe_o,
   input wire logic conv_done_i,
   input wire logic conv_start_o,
   input wire logic power_up_o,
   input wire logic [1:0] conv_chan_o,
   input wire logic hs_mode_o
);
   // ****************
   // checks on the system clock
   // ****************
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   property p_pulse; conv_start_o |=> !conv_start_o; endproperty
   a_pulse: assert property (p_pulse) else $error("start held longer than one cycle");
   property p_wake; $rose(power_up_o) |-> ##70 conv_start_o; endproperty
   a_wake: assert property (p_wake) else $error("sampling not 70 cycles after wake");
   property p_awake; conv_start_o |-> power_up_o; endproperty
   a_awake: assert property (p_awake) else $error("conversion started in shutdown");
   property p_chan; conv_start_o |-> ##1 $stable(conv_chan_o) [*5]; endproperty
   a_chan: assert property (p_chan) else $error("channel moved during conversion");
   property p_drop; $fell(power_up_o) |-> $past(conv_done_i) || $past(conv_done_i, 2); endproperty
   a_drop: assert property (p_drop) else $error("shutdown without a finished conversion");
   property p_oe; $rose(sda_oe_o) |-> !scl_i; endproperty
   a_oe: assert property (p_oe) else $error("data line pulled while clock high");
   property p_hs_stop; $fell(hs_mode_o) |-> scl_i && sda_i; endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("fast mode left without stop");
   property p_hs_nak; $rose(hs_mode_o) |-> !sda_oe_o throughout (##30 1'b1); endproperty
   a_hs_nak: assert property (p_hs_nak) else $error("master code acknowledged");
endmodule // aci_monitor

bind aci_top aci_monitor aci_monitor_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o), .power_up_o(power_up_o),
   .conv_chan_o(conv_chan_o), .hs_mode_o(hs_mode_o));

// ==== verification/testbench.sv ====
// testbench: exercises the converter command interface over the two-wire bus
// assumes aci_top, aci_bus_master and aci_monitor are compiled before it
`timescale 1ns/1ps
module testbench
   import aci_pkg::*;
;
   logic mclk_i = 1'b0, nrst_i = 1'b0, lclk = 1'b0, conv_done_i = 1'b0;
   logic [11:0] conv_data_i = 12'h0000;
   logic sda_o, sda_oe_o, power_up_o, conv_start_o, hs_mode_o, a;
   logic [1:0] conv_chan_o;
   logic [7:0] config_o, hi, lo;
   wire scl, m_low, sda;
   int failures = 0, comparisons = 0, starts = 0, cnt = 0, base = 0;
   // open-drain data wire with pull-up
   assign sda = !(sda_oe_o || m_low);
   initial forever #5 mclk_i = ~mclk_i;
   initial begin
      #2.3;
      forever #3 lclk = ~lclk;
   end
   aci_bus_master aci_bus_master_i (.lclk_i(lclk), .scl_o(scl), .low_o(m_low), .sda_i(sda));
   aci_top aci_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .power_up_o(power_up_o),
      .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .config_o(config_o), .hs_mode_o(hs_mode_o));
   // analogue core stand-in: done 20 cycles after start, value tagged by channel
   always @(negedge mclk_i) begin
      conv_done_i <= (cnt == 1);
      conv_data_i <= 12'h05A0 + 12'(conv_chan_o);
      cnt <= conv_start_o ? 20 : (cnt > 0 ? cnt - 1 : 0);
      starts <= starts + int'(conv_start_o);
   end
   function automatic logic [15:0] res(input logic [1:0] ch);
      return {2'b00, ch, (12'h05A0 + 12'(ch)) & DATA_MASK};
   endfunction
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] ad, input logic [7:0] d, input logic ack_exp);
      aci_bus_master_i.start();
      aci_bus_master_i.xfer({ad, 1'b0}, 1'b1, lo, a);
      chk("write address ack", 16'(a), 16'(!ack_exp));
      if (!a) aci_bus_master_i.xfer(d, 1'b1, lo, a);
      aci_bus_master_i.stop();
   endtask
   // read n results, acknowledging all but the last
   task automatic rd(input int n, input logic [15:0] exp [$]);
      aci_bus_master_i.start();
      aci_bus_master_i.xfer({DEV_ADDR, 1'b1}, 1'b1, lo, a);
      chk("read address ack", 16'(a), 16'h0000);
      chk("data drive value", 16'(sda_o), 16'h0000);
      for (int k = 0; k < n; k++) begin
         aci_bus_master_i.xfer(8'hFF, 1'b0, hi, a);
         aci_bus_master_i.xfer(8'hFF, k == n - 1, lo, a);
         chk("result", {hi, lo}, exp[k]);
      end
      aci_bus_master_i.stop();
   endtask
   task automatic end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // watchdog, about three times the expected run
   initial begin
      #250us;
      failures++;
      $display("watchdog expired");
      end_sim();
   end
   // main sequence
   initial begin
      repeat (20) @(negedge mclk_i);
      nrst_i = 1'b1;
      repeat (6) @(negedge mclk_i);
      chk("config at reset", 16'(config_o), 16'(CFG_RESET));
      chk("awake at reset", 16'(power_up_o), 16'h0000);
      $display("test reset done");
      rd(4, '{16'h0000, res(2'd0), res(2'd1), res(2'd2)});
      repeat (300) @(negedge mclk_i);
      chk("conversion count", 16'(starts), 16'h0004);
      chk("awake after nack", 16'(power_up_o), 16'h0000);
      $display("test default sequence done");
      wr(DEV_ADDR, 8'h50, 1'b1);
      chk("config", 16'(config_o), 16'h0050);
      rd(3, '{res(2'd3), res(2'd0), res(2'd2)});
      $display("test two channels done");
      wr(DEV_ADDR, 8'h20, 1'b1);
      rd(3, '{res(2'd0), res(2'd1), res(2'd1)});
      $display("test single channel done");
      wr(DEV_ADDR ^ 7'h01, 8'h10, 1'b0);
      chk("config kept", 16'(config_o), 16'h0020);
      $display("test foreign address done");
      aci_bus_master_i.start();
      aci_bus_master_i.xfer(8'h08, 1'b1, lo, a);
      chk("master code ack", 16'(a), 16'h0001);
      chk("fast mode", 16'(hs_mode_o), 16'h0001);
      rd(1, '{res(2'd1)});
      repeat (10) @(negedge mclk_i);
      chk("fast mode after stop", 16'(hs_mode_o), 16'h0000);
      $display("test high speed done");
      base = starts;
      wr(DEV_ADDR, 8'h00, 1'b1);
      chk("config none", 16'(config_o), 16'h0000);
      rd(2, '{res(2'd1), res(2'd1)});
      repeat (300) @(negedge mclk_i);
      chk("conversions with none selected", 16'(starts - base), 16'h0000);
      chk("awake with none selected", 16'(power_up_o), 16'h0000);
      $display("test no channel done");
      end_sim();
   end
endmodule // testbench

// ==== verilog/aci_pkg.sv ====
// aci_pkg: constants, field layout and types for the converter's two-wire command interface
// assumes a 100 MHz system clock and a bus clock that only toggles during frames
package aci_pkg;

   // ************************************************************
   // system clock and wake-up timing
   // ************************************************************
   localparam int MCLK_MHZ = 100;
   localparam int WAKE_NS = 700;                                    // power-up to sampling delay
   localparam int WAKE_CYC_I = (WAKE_NS * MCLK_MHZ + 999) / 1000;   // rounded up to whole cycles
   localparam logic [6:0] WAKE_CYC = 7'(WAKE_CYC_I - 1);            // counter load value

   // ************************************************************
   // bus addressing
   // ************************************************************
   localparam logic [6:0] DEV_ADDR = 7'h28;        // own 7-bit bus address, value arbitrary
   localparam logic [4:0] HS_CODE = 5'h01;         // upper five bits of the high-speed master code
   localparam logic [2:0] LAST_BIT = 3'h7;         // index of the eighth bit of a byte

   // ************************************************************
   // configuration register layout
   // ************************************************************
   localparam logic [7:0] CFG_RESET = 8'hF0;       // all four channels enabled, bits 3..0 clear
   localparam int CFG_CH_LSB = 4;                  // channel enables occupy bits 7..4
   localparam int CH_COUNT = 4;

   // ************************************************************
   // conversion result layout
   // ************************************************************
   localparam int RESULT_BITS = 12;                // 12, 10 or 8 for the three variants
   localparam int DATA_W = 12;
   localparam logic [11:0] DATA_MASK = 12'(12'hFFF << (DATA_W - RESULT_BITS));
   localparam logic [1:0] LEAD_ZEROS = 2'h0;

   // ************************************************************
   // state types
   // ************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_WR_DATA, ST_WR_ACK,
      ST_IGNORE} aci_bus_st_t;

   typedef enum logic [1:0] {CV_OFF, CV_WAKE, CV_CONV} aci_conv_st_t;

endpackage

// ==== verilog/aci_top.sv ====
// aci_top: two-wire bus slave and conversion sequencer of a four-channel converter
// assumes an external analogue core that answers conv_start_o with conv_done_i and data;
// scl_i clocks only the bit capture at the link, the rest runs on mclk_i
//
// Functional notes
// - default configuration sequences all four channels
// - every read returns a two-byte result
// - results keep coming while master acknowledges
// - acknowledge read address, send status first
// - first byte: status nibble, result top nibble
// - second byte: low bits, variant zero padded
// - power up at ninth rise, sample later
// - master ack after second byte: convert again
// - master nack: no power up, no conversion
// - next conversion takes next selected channel
// - single channel selected: same channel again
// - never acknowledge the high-speed code
// - repeated start and address follow at speed
// - high-speed mode held until stop condition
// - start in shutdown, wake on read address ack
// - channel enables of configuration pick channels
// - enables bits 7..4, ascending from lowest
`timescale 1ns/1ps
module aci_top
   import aci_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic conv_done_i,
   input wire logic [11:0] conv_data_i,
   output logic power_up_o,
   output logic conv_start_o,
   output logic [1:0] conv_chan_o,
   output logic [7:0] config_o,
   output logic hs_mode_o
);

   // ************************************************************
   // types and helpers
   // ************************************************************
   typedef struct packed {
      logic [2:0] scl_s;         // sync stage 1, stage 2, previous
      logic [2:0] sda_s;
      logic [1:0] lbit_s;        // captured link bit, two stages
      aci_bus_st_t st;
      logic got_rise;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic second;
      logic mack;
      logic [7:0] tx;
      logic [7:0] snap_lo;
      logic oe;
      logic drv;
      logic hs;
      logic [7:0] cfg;
      logic [15:0] result;
      aci_conv_st_t cst;
      logic [6:0] wait_cnt;
      logic pwr;
      logic start;
      logic pend;
      logic pend_first;
      logic [1:0] chan;
   } aci_state_t;

   // next enabled channel, from the lowest when restarting, wrapping otherwise
   function automatic logic [1:0] next_chan(input logic [3:0] sel, input logic [1:0] cur,
      input logic restart);
      logic [1:0] c;
      logic [1:0] pick;
      logic found;
      pick = cur;
      found = 1'b0;
      for (int i = 0; i < CH_COUNT; i++) begin
         c = restart ? 2'(i) : 2'(cur + 2'(i + 1));
         if (!found && sel[c]) begin
            pick = c;
            found = 1'b1;
         end
      end
      return pick;
   endfunction

   // ************************************************************
   // reset release
   // ************************************************************
   logic [1:0] rst_sync_q;
   logic rst_n;

   // reset asserts at once and releases after two clocks
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ************************************************************
   // link domain: bit capture on the bus clock
   // ************************************************************
   logic link_bit_q;

   // data is stable while the bus clock is high, so catch it on the rising edge
   always_ff @(posedge scl_i or negedge rst_n) begin
      if (!rst_n) begin
         link_bit_q <= 1'b1;
      end else begin
         link_bit_q <= sda_i;
      end
   end

   // ************************************************************
   // system domain: protocol engine and sequencer
   // ************************************************************
   aci_state_t q;
   aci_state_t d;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic rx_bit;
   logic req;
   logic req_first;
   logic [7:0] rx_byte;
   logic [3:0] ch_sel;

   // edge and condition decode on the second sync stage only
   always_comb begin
      scl_rise = q.scl_s[1] & ~q.scl_s[2];
      scl_fall = ~q.scl_s[1] & q.scl_s[2];
      bus_start = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
      bus_stop = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];
      rx_bit = q.lbit_s[1];
      rx_byte = {q.sh[6:0], rx_bit};
      ch_sel = q.cfg[CFG_CH_LSB +: CH_COUNT];
   end

   // next-state logic for the whole block
   always_comb begin
      d = q;
      d.start = 1'b0;
      req = 1'b0;
      req_first = 1'b0;
      d.scl_s = {q.scl_s[1:0], scl_i};
      d.sda_s = {q.sda_s[1:0], sda_i};
      d.lbit_s = {q.lbit_s[0], link_bit_q};

      // bus engine: decisions on the rise need the sampled level, all else on the fall
      if (bus_stop) begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
         d.hs = 1'b0;
      end else if (bus_start) begin
         d.st = ST_ADDR;
         d.cnt = 3'h0;
         d.oe = 1'b0;
         d.got_rise = 1'b0;
      end else if (scl_rise) begin
         d.got_rise = 1'b1;
         if (q.st == ST_ADDR_ACK && q.rw) begin
            req = 1'b1;
            req_first = 1'b1;
         end
         if (q.st == ST_RD_ACK) begin
            d.mack = ~q.sda_s[1];
            req = ~q.sda_s[1] & q.second;
         end
      end else if (scl_fall && q.got_rise) begin
         case (q.st)
            ST_ADDR: begin
               d.sh = rx_byte;
               d.cnt = q.cnt + 3'h1;
               if (q.cnt == LAST_BIT) begin
                  if (rx_byte[7:3] == HS_CODE) begin
                     d.hs = 1'b1;
                     d.st = ST_IGNORE;
                  end else if (rx_byte[7:1] == DEV_ADDR) begin
                     d.rw = rx_byte[0];
                     d.oe = 1'b1;
                     d.st = ST_ADDR_ACK;
                  end else begin
                     d.st = ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               d.cnt = 3'h0;
               if (q.rw) begin
                  d.tx = q.result[15:8];
                  d.snap_lo = q.result[7:0];
                  d.second = 1'b0;
                  d.oe = ~q.result[15];
                  d.st = ST_RD_BYTE;
               end else begin
                  d.oe = 1'b0;
                  d.st = ST_WR_DATA;
               end
            end
            ST_RD_BYTE: begin
               d.cnt = q.cnt + 3'h1;
               d.tx = {q.tx[6:0], 1'b0};
               if (q.cnt == LAST_BIT) begin
                  d.oe = 1'b0;                               // release for the master's ack
                  d.st = ST_RD_ACK;
               end else begin
                  d.oe = ~q.tx[6];
               end
            end
            ST_RD_ACK: begin
               d.cnt = 3'h0;
               if (q.mack) begin
                  d.st = ST_RD_BYTE;
                  if (!q.second) begin
                     d.tx = q.snap_lo;
                     d.second = 1'b1;
                     d.oe = ~q.snap_lo[7];
                  end else begin
                     d.tx = q.result[15:8];
                     d.snap_lo = q.result[7:0];
                     d.second = 1'b0;
                     d.oe = ~q.result[15];
                  end
               end else begin
                  d.oe = 1'b0;
                  d.st = ST_IGNORE;
               end
            end
            ST_WR_DATA: begin
               d.sh = rx_byte;
               d.cnt = q.cnt + 3'h1;
               if (q.cnt == LAST_BIT) begin
                  d.cfg = rx_byte;
                  d.oe = 1'b1;
                  d.st = ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               d.oe = 1'b0;                                  // further bytes left unacknowledged
               d.st = ST_IGNORE;
            end
            ST_IDLE, ST_IGNORE: begin
               d.st = q.st;
            end
            default: begin
               d.st = ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end

      // conversion sequencer: wake, wait, start, collect, back to shutdown
      case (q.cst)
         CV_OFF: begin
            if (req && ch_sel != 4'h0) begin
               d.chan = next_chan(ch_sel, q.chan, req_first);
               d.pwr = 1'b1;
               d.wait_cnt = WAKE_CYC;
               d.cst = CV_WAKE;
            end
         end
         CV_WAKE: begin
            if (req) begin
               d.pend = 1'b1;
               d.pend_first = req_first;
            end
            if (q.wait_cnt == 7'h0) begin
               d.start = 1'b1;
               d.cst = CV_CONV;
            end else begin
               d.wait_cnt = q.wait_cnt - 7'h1;
            end
         end
         CV_CONV: begin
            if (req) begin
               d.pend = 1'b1;
               d.pend_first = req_first;
            end
            if (conv_done_i) begin
               d.result = {LEAD_ZEROS, q.chan, conv_data_i & DATA_MASK};
               if ((q.pend || req) && ch_sel != 4'h0) begin
                  d.chan = next_chan(ch_sel, q.chan, q.pend ? q.pend_first : req_first);
                  d.pend = 1'b0;
                  d.wait_cnt = WAKE_CYC;
                  d.cst = CV_WAKE;
               end else begin
                  d.pend = 1'b0;
                  d.pwr = 1'b0;
                  d.cst = CV_OFF;
               end
            end
         end
         default: begin
            d.pwr = 1'b0;
            d.cst = CV_OFF;
         end
      endcase
   end

   // single register bank for all system-domain state
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.lbit_s <= 2'h3;
         q.st <= ST_IDLE;
         q.got_rise <= 1'b0;
         q.cnt <= 3'h0;
         q.sh <= 8'h00;
         q.rw <= 1'b0;
         q.second <= 1'b0;
         q.mack <= 1'b0;
         q.tx <= 8'h00;
         q.snap_lo <= 8'h00;
         q.oe <= 1'b0;
         q.drv <= 1'b0;
         q.hs <= 1'b0;
         q.cfg <= CFG_RESET;
         q.result <= 16'h0000;
         q.cst <= CV_OFF;
         q.wait_cnt <= 7'h00;
         q.pwr <= 1'b0;
         q.start <= 1'b0;
         q.pend <= 1'b0;
         q.pend_first <= 1'b0;
         q.chan <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // every output is a field of the state register
   assign sda_o = q.drv;
   assign sda_oe_o = q.oe;
   assign power_up_o = q.pwr;
   assign conv_start_o = q.start;
   assign conv_chan_o = q.chan;
   assign config_o = q.cfg;
   assign hs_mode_o = q.hs;

endmodule // aci_top
